// File: mux_adc_seq_step_config.sv
// step-10 and step-11 configuration registers of the second mux converter sequencer
// assumes a plain register port on the system clock and a sequencer outside
// assumes strobes are one cycle long and never both high in one cycle
// assumes the sequencer request is already on the system clock
//
// Contract
// - bit 15 enables sequencer step 10; read/write, resets to 0.
// - bits 14:13 set step 10 gain: 00=1, 01=2, 10 and 11=4.
// - bits 12:5 reserved, read-only, always read zero.
// - bit 4 picks negative input: 0 ground reference, 1 external input seven.
// - positive codes 0 to 7 route external input n.
// - codes 8 and above pick internal sources: temperature, short, test DAC, monitors.
// - internal sources pick their own negative input, ignoring bit 4.
// - step 11 register sits at DBh, resets to 000Bh.
`timescale 1ns/1ps
`default_nettype none
`include "mux_seq_cfg.svh"
module mux_adc_seq_step_config (
  // clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CLK_EN,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  // sequencer request for step 10
  input wire logic I_STEP10_REQ,
  // step 10 settings toward converter
  output logic O_STEP10_CONVERT,
  output logic O_STEP10_ENABLE,
  output logic [1:0] O_STEP10_GAIN,
  output logic [3:0] O_STEP10_POS_SEL,
  output logic [1:0] O_STEP10_NEG_SRC,
  // step 11 raw register
  output logic [15:0] O_STEP11_CFG
);
  //****************************************
  // registers
  //****************************************
  logic [15:0] step10_cfg;
  logic [15:0] step11_cfg;
  logic [15:0] rdata;
  logic convert;

  // address decode
  wire sel10 = (I_ADDR == `STEP10_CFG_ADDR);
  wire sel11 = (I_ADDR == `STEP11_CFG_ADDR);
  wire wr10 = I_CLK_EN & I_WR & sel10;
  wire wr11 = I_CLK_EN & I_WR & sel11;
  wire [15:0] wmasked = I_WDATA & `CFG_WRITE_MASK;
  wire [15:0] next_rdata = sel10 ? step10_cfg : (sel11 ? step11_cfg : 16'h0000);

  // field decode for step 10
  wire step10_enable = step10_cfg[`CFG_ENABLE_BIT];
  wire [1:0] step10_gain_select = step10_cfg[`CFG_GAIN_HI:`CFG_GAIN_LO];
  wire step10_negative_input_select = step10_cfg[`CFG_NEG_BIT];
  wire [3:0] step10_positive_input_select = step10_cfg[`CFG_POS_HI:`CFG_POS_LO];
  wire pos_internal = (step10_positive_input_select >= `POS_INTERNAL_FIRST);
  wire [1:0] gain_dec = (step10_gain_select == 2'h0) ? mux_seq_pkg::GAIN_X1 :
                        (step10_gain_select == 2'h1) ? mux_seq_pkg::GAIN_X2 :
                        mux_seq_pkg::GAIN_X4;
  wire [1:0] neg_dec = pos_internal ? mux_seq_pkg::NEG_AUTOMATIC :
                       (step10_negative_input_select ? mux_seq_pkg::NEG_EXT_SEVEN :
                        mux_seq_pkg::NEG_GROUND_REF);

  // register writes
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      step10_cfg <= `STEP10_CFG_RESET;
      step11_cfg <= `STEP11_CFG_RESET;
    end else begin
      if (wr10) begin
        step10_cfg <= wmasked;
      end
      if (wr11) begin
        step11_cfg <= wmasked;
      end
    end
  end

  // read data, one cycle after the strobe only
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      rdata <= 16'h0000;
    end else if (I_CLK_EN) begin
      rdata <= I_RD ? next_rdata : 16'h0000;
    end
  end

  // conversion grant for step 10, skipped when disabled
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      convert <= 1'b0;
    end else if (I_CLK_EN) begin
      convert <= I_STEP10_REQ & step10_enable;
    end
  end

  //****************************************
  // outputs
  //****************************************
  assign O_RDATA = rdata;
  assign O_STEP10_CONVERT = convert;
  assign O_STEP10_ENABLE = step10_enable;
  assign O_STEP10_GAIN = gain_dec;
  assign O_STEP10_POS_SEL = step10_positive_input_select;
  assign O_STEP10_NEG_SRC = neg_dec;
  assign O_STEP11_CFG = step11_cfg;

  //****************************************
  // assertion building blocks
  //****************************************
  // accepted write to the step-10 register
  sequence s_wr10;
    I_CLK_EN && I_WR && sel10;
  endsequence : s_wr10

  // accepted write to the step-11 register
  sequence s_wr11;
    I_CLK_EN && I_WR && sel11;
  endsequence : s_wr11

  // accepted read of the step-10 register
  sequence s_rd10;
    I_CLK_EN && I_RD && sel10;
  endsequence : s_rd10

  // enabled cycle with no read strobe
  sequence s_rd_idle;
    I_CLK_EN && !I_RD;
  endsequence : s_rd_idle

  // cycle frozen by the clock enable
  sequence s_frozen;
    !I_CLK_EN;
  endsequence : s_frozen

  //****************************************
  // assertions: reserved bits
  //****************************************
  // reserved field never shows on the read port
  a_reserved_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_RDATA[12:5] == 8'h00) else $error("reserved bits read nonzero");

  // reserved field never stored in step 10
  a_step10_reserved: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    step10_cfg[12:5] == 8'h00) else $error("step 10 reserved bits set");

  // reserved field never stored in step 11
  a_step11_reserved: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_STEP11_CFG[12:5] == 8'h00) else $error("step 11 reserved bits set");

  //****************************************
  // assertions: write path
  //****************************************
  // enable bit lands one cycle after the strobe
  a_enable_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr10 |=> O_STEP10_ENABLE == $past(I_WDATA[15])) else $error("enable not stored");

  // gain field lands one cycle after the strobe
  a_gain_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_wr10 |=> step10_gain_select == $past(I_WDATA[14:13])) else $error("gain not stored");

  // negative select lands one cycle after the strobe
  a_neg_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_wr10 |=> step10_negative_input_select == $past(I_WDATA[4])) else $error("negative not stored");

  // positive code lands one cycle after the strobe
  a_pos_route: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr10 |=> O_STEP10_POS_SEL == $past(I_WDATA[3:0])) else $error("positive select not stored");

  // step 11 keeps only its writable bits
  a_step11_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_wr11 |=> O_STEP11_CFG == ($past(I_WDATA) & `CFG_WRITE_MASK)) else $error("step 11 not stored");

  // writes elsewhere leave both registers alone
  a_hold_cfg: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !(I_CLK_EN && I_WR && (sel10 || sel11)) |=> $stable(step10_cfg) && $stable(step11_cfg))
    else $error("register changed without write");

  //****************************************
  // assertions: field decode
  //****************************************
  // codes 10b and 11b both give gain four
  a_gain_four: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    step10_gain_select[1] |-> O_STEP10_GAIN == 2'h2) else $error("gain not four");

  // codes 00b and 01b map straight through
  a_gain_low: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !step10_gain_select[1] |-> O_STEP10_GAIN == step10_gain_select) else $error("gain wrong");

  // decoded gain never takes the unused code
  a_gain_legal: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_STEP10_GAIN != 2'h3) else $error("gain code illegal");

  // external codes follow the negative select bit
  a_neg_manual: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !step10_positive_input_select[3] |-> O_STEP10_NEG_SRC == {1'b0, step10_negative_input_select})
    else $error("negative select wrong");

  // external codes never get the automatic negative
  a_pos_external: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !step10_positive_input_select[3] |-> O_STEP10_NEG_SRC != 2'h2) else $error("external code automatic");

  // internal codes override the negative select bit
  a_neg_auto: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    step10_positive_input_select[3] |-> O_STEP10_NEG_SRC == 2'h2) else $error("auto negative missed");

  //****************************************
  // assertions: read path
  //****************************************
  // step 10 contents appear the cycle after the strobe
  a_step10_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_rd10 |=> O_RDATA == $past(step10_cfg)) else $error("step 10 read wrong");

  // step 11 contents appear the cycle after the strobe
  a_step11_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_CLK_EN && I_RD && I_ADDR == 8'hDB) |=> O_RDATA == step11_cfg) else $error("step 11 read wrong");

  // unknown addresses read as zero
  a_read_other: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_CLK_EN && I_RD && !sel10 && !sel11) |=> O_RDATA == 16'h0000) else $error("other address nonzero");

  // read data stands for one cycle only
  a_read_one_cycle: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (s_rd10 ##1 s_rd_idle) |=> O_RDATA == 16'h0000) else $error("read data lingered");

  // no strobe, no read data
  a_read_idle: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_rd_idle |=> O_RDATA == 16'h0000) else $error("idle read data nonzero");

  //****************************************
  // assertions: clock enable freeze
  //****************************************
  // frozen cycle keeps both registers
  a_freeze_cfg: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_frozen |=> $stable(step10_cfg) && $stable(step11_cfg)) else $error("frozen register changed");

  // frozen cycle keeps the read port
  a_freeze_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_frozen |=> $stable(O_RDATA)) else $error("frozen read data changed");

  // frozen cycle keeps the grant
  a_freeze_grant: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_frozen |=> $stable(O_STEP10_CONVERT)) else $error("frozen grant changed");

  //****************************************
  // assertions: step grant
  //****************************************
  // disabled step is skipped
  a_skip_disabled: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_CLK_EN && !step10_enable) |=> !O_STEP10_CONVERT) else $error("disabled step converted");

  // enabled step with a request is granted
  a_convert_grant: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_CLK_EN && I_STEP10_REQ && step10_enable) |=> O_STEP10_CONVERT) else $error("grant missed");

  // no request, no grant
  a_grant_needs_req: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_CLK_EN && !I_STEP10_REQ) |=> !O_STEP10_CONVERT) else $error("grant without request");
endmodule : mux_adc_seq_step_config
`default_nettype wire

// File: mux_adc_seq_step_config_tb.sv
// testbench for the step-10/11 sequencer configuration registers
// assumes design, package and header are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "mux_seq_cfg.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module mux_adc_seq_step_config_tb;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0, req = 1'b0, r, conv, en;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, s11, d;
  logic [1:0] gain, neg;
  logic [3:0] pos;
  int fail_count = 0, checks = 0, cycles = 0;
  // ****
  // clock, design, helpers
  // ****
  always #5 clk = ~clk;
  mux_adc_seq_step_config DUT (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CLK_EN(clk_en), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_STEP10_REQ(req), .O_STEP10_CONVERT(conv),
    .O_STEP10_ENABLE(en), .O_STEP10_GAIN(gain), .O_STEP10_POS_SEL(pos), .O_STEP10_NEG_SRC(neg),
    .O_STEP11_CFG(s11));
  // expected gain and negative source from raw fields
  function automatic mux_seq_pkg::gain_t exp_gain(input logic [1:0] g);
    return (g == 2'h0) ? mux_seq_pkg::GAIN_X1 : (g == 2'h1) ? mux_seq_pkg::GAIN_X2 : mux_seq_pkg::GAIN_X4;
  endfunction : exp_gain
  function automatic mux_seq_pkg::neg_src_t exp_neg(input logic [15:0] v);
    return v[3] ? mux_seq_pkg::NEG_AUTOMATIC : (v[4] ? mux_seq_pkg::NEG_EXT_SEVEN : mux_seq_pkg::NEG_GROUND_REF);
  endfunction : exp_neg
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask : wr_reg
  // read, data only in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
    @(negedge clk);
    `CHK(rdata, 16'h0000)
  endtask : rd_chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    void'($urandom(52));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({en, gain, pos, neg}, {1'b0, 2'h0, 4'hA, 2'h2})
    `CHK(s11, 16'h000B)
    rd_chk(8'hDA, 16'h000A);
    rd_chk(8'hDB, 16'h000B);
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      d = 16'($urandom);
      d[4:0] = i[4:0];
      if (i == 31) d[14:13] = 2'h3;
      wr_reg(8'hDA, d);
      `CHK(en, d[15])
      `CHK(gain, exp_gain(d[14:13]))
      `CHK(pos, d[3:0])
      `CHK(neg, exp_neg(d))
      r = 1'($urandom);
      @(posedge clk);
      req <= r;
      @(posedge clk);
      @(negedge clk);
      `CHK(conv, r & d[15])
      rd_chk(8'hDA, d & 16'hE01F);
    end
    $display("random test done");
    wr_reg(8'hD9, 16'hFFFF);
    `CHK(pos, d[3:0])
    rd_chk(8'hD9, 16'h0000);
    @(posedge clk);
    clk_en <= 1'b0;
    wr_reg(8'hDA, ~d);
    @(posedge clk);
    clk_en <= 1'b1;
    @(negedge clk);
    `CHK(pos, d[3:0])
    $display("refusal test done");
    wr_reg(8'hDB, 16'hFFFF);
    `CHK(s11, 16'hE01F)
    rd_chk(8'hDB, 16'hE01F);
    `CHK(pos, d[3:0])
    $display("step 11 test done");
    wrap_up();
  end
endmodule : mux_adc_seq_step_config_tb
`default_nettype wire

// File: mux_seq_cfg.svh
// constants for the step-10/11 sequencer configuration registers
// assumes inclusion by bare name from the design file and the testbench
`ifndef MUX_SEQ_CFG_SVH
`define MUX_SEQ_CFG_SVH
// register offsets (byte address on the plain register port)
`define STEP10_CFG_ADDR 8'hDA
`define STEP11_CFG_ADDR 8'hDB
// reset values
`define STEP10_CFG_RESET 16'h000A
`define STEP11_CFG_RESET 16'h000B
// field positions
`define CFG_ENABLE_BIT 15
`define CFG_GAIN_HI 14
`define CFG_GAIN_LO 13
`define CFG_NEG_BIT 4
`define CFG_POS_HI 3
`define CFG_POS_LO 0
// mask of writable bits (reserved 12:5 read zero)
`define CFG_WRITE_MASK 16'hE01F
// first positive code that picks an internal source
`define POS_INTERNAL_FIRST 4'h8
`endif

// File: mux_seq_pkg.sv
// types for the step configuration registers
// assumes mux_seq_cfg.svh holds the numbers
`default_nettype none
package mux_seq_pkg;
  // decoded converter gain
  typedef enum logic [1:0] {
    GAIN_X1 = 2'h0,
    GAIN_X2 = 2'h1,
    GAIN_X4 = 2'h2
  } gain_t;
  // source of the converter negative input
  typedef enum logic [1:0] {
    NEG_GROUND_REF = 2'h0,
    NEG_EXT_SEVEN = 2'h1,
    NEG_AUTOMATIC = 2'h2
  } neg_src_t;
endpackage : mux_seq_pkg
`default_nettype wire
